// ==== asx_alu.sv ====
// Subtract, exclusive-or and nibble-exchange datapath slice
//
// Function
// - literal minus accumulator into accumulator, C DC Z
// - accumulator xor literal into accumulator, Z only
// - register minus accumulator to destination, C DC Z
// - swap register nibbles, flags unchanged
// - accumulator xor register to destination, Z only
// - destination bit 0 accumulator, 1 register
`timescale 1ns/1ps
`include "asx_map.svh"
module asx_alu #(
    parameter int DATA_W = `ASX_DATA_W,
    parameter int ADDR_W = `ASX_ADDR_W,
    parameter int DEPTH = `ASX_REG_DEPTH
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Operation request from the decoder
    input wire logic i_start,
    input wire asx_pkg::asx_op_t i_op,
    input wire logic [DATA_W-1:0] i_literal,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic i_dest_sel,
    // Register file preload port
    input wire logic i_rf_wr,
    input wire logic [ADDR_W-1:0] i_rf_addr,
    input wire logic [DATA_W-1:0] i_rf_data,
    // Architectural state out
    output logic [DATA_W-1:0] o_acc,
    output logic o_carry,
    output logic o_digit_carry_flag,
    output logic o_zero,
    // Completion and register write-back view
    output logic o_done,
    output logic o_busy,
    output logic o_reg_wr,
    output logic [ADDR_W-1:0] o_reg_wr_addr,
    output logic [DATA_W-1:0] o_reg_wr_data
);
    import asx_pkg::*;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ASX_IDLE = 3'b001,
        ASX_FETCH = 3'b010,
        ASX_EXEC = 3'b100
    } asx_state_t;

    // Subtraction result with inverted borrows
    typedef struct packed {
        logic [DATA_W-1:0] res;
        logic c;
        logic dc;
    } asx_sub_t;

    // a minus b by adding the complement plus one
    function automatic asx_sub_t sub_nb(input logic [DATA_W-1:0] a,
                                        input logic [DATA_W-1:0] b);
        asx_sub_t r;
        logic [DATA_W:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, 1'b1};
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        r.res = full[DATA_W-1:0];
        r.c = full[DATA_W];
        r.dc = low[4];
        return r;
    endfunction : sub_nb

    // Nibble exchange of a byte
    function automatic logic [DATA_W-1:0] swap_nib(
        input logic [DATA_W-1:0] v);
        return {v[`ASX_NIB_LO:0], v[`ASX_NIB_HI:`ASX_NIB_LO+1]};
    endfunction : swap_nib

    // Latched request
    asx_state_t state_ff;
    asx_op_t op_ff;
    logic [DATA_W-1:0] lit_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic dest_ff;
    // Register file read data
    logic [DATA_W-1:0] rf_rd;
    // Write-back enable into the register file
    logic rf_we;
    logic [ADDR_W-1:0] rf_wa;
    logic [DATA_W-1:0] rf_wd;
    // Combinational results
    asx_sub_t nxt_sub;
    logic [DATA_W-1:0] nxt_res;
    logic nxt_to_reg;

    // Register file instance
    asx_regfile #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W),
        .DEPTH(DEPTH)
    ) u_rf (
        .i_clk_sys(i_clk_sys),
        .i_wr_en(rf_we),
        .i_wr_addr(rf_wa),
        .i_wr_data(rf_wd),
        .i_rd_addr(i_start ? i_reg_addr : addr_ff),
        .o_rd_data(rf_rd)
    );

    // Sequencer: idle, wait one cycle for read data, execute
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state_ff <= ASX_IDLE;
        end
        else
        begin
            unique case (state_ff)
                ASX_IDLE:
                begin
                    if (i_start)
                    begin
                        state_ff <= ASX_FETCH;
                    end
                end
                ASX_FETCH: state_ff <= ASX_EXEC;
                ASX_EXEC: state_ff <= ASX_IDLE;
                default: state_ff <= ASX_IDLE;
            endcase
        end
    end

    // Capture the request only when idle; a later start in FETCH still switches the register read address
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            op_ff <= ASX_NONE;
            lit_ff <= '0;
            addr_ff <= '0;
            dest_ff <= `ASX_DEST_ACC;
        end
        else if (i_start && state_ff == ASX_IDLE)
        begin
            op_ff <= i_op;
            lit_ff <= i_literal;
            addr_ff <= i_reg_addr;
            dest_ff <= i_dest_sel;
        end
    end

    // Operand selection and result
    always_comb
    begin
        nxt_sub = sub_nb(lit_ff, o_acc);
        nxt_res = o_acc;
        nxt_to_reg = 1'b0;
        unique case (op_ff)
            ASX_LIT_SUB:
            begin
                nxt_res = nxt_sub.res;
            end
            ASX_LIT_XOR:
            begin
                nxt_res = o_acc ^ lit_ff;
            end
            ASX_REG_SUB:
            begin
                nxt_sub = sub_nb(rf_rd, o_acc);
                nxt_res = nxt_sub.res;
                nxt_to_reg = dest_ff;
            end
            ASX_SWAP:
            begin
                nxt_res = swap_nib(rf_rd);
                nxt_to_reg = dest_ff;
            end
            ASX_REG_XOR:
            begin
                nxt_res = o_acc ^ rf_rd;
                nxt_to_reg = dest_ff;
            end
            default:
            begin
                nxt_res = o_acc;
            end
        endcase
    end

    // Write-back path, preload only when idle
    always_comb
    begin
        if (state_ff == ASX_EXEC && nxt_to_reg)
        begin
            rf_we = 1'b1;
            rf_wa = addr_ff;
            rf_wd = nxt_res;
        end
        else
        begin
            rf_we = i_rf_wr && state_ff == ASX_IDLE;
            rf_wa = i_rf_addr;
            rf_wd = i_rf_data;
        end
    end

    // Accumulator update
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_acc <= `ASX_ACC_RST;
        end
        else if (state_ff == ASX_EXEC && op_ff != ASX_NONE && !nxt_to_reg)
        begin
            o_acc <= nxt_res;
        end
    end

    // Carry and digit carry only on subtractions
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_carry <= `ASX_FLAG_RST;
            o_digit_carry_flag <= `ASX_FLAG_RST;
        end
        else if (state_ff == ASX_EXEC &&
                 (op_ff == ASX_LIT_SUB || op_ff == ASX_REG_SUB))
        begin
            o_carry <= nxt_sub.c;
            o_digit_carry_flag <= nxt_sub.dc;
        end
    end

    // Zero flag on all but the nibble exchange and ASX_NONE
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_zero <= `ASX_FLAG_RST;
        end
        else if (state_ff == ASX_EXEC && op_ff != ASX_SWAP &&
                 op_ff != ASX_NONE)
        begin
            o_zero <= (nxt_res == '0);
        end
    end

    // Handshake and write-back mirror, all registered
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_done <= 1'b0;
            o_busy <= 1'b0;
            o_reg_wr <= 1'b0;
            o_reg_wr_addr <= '0;
            o_reg_wr_data <= '0;
        end
        else
        begin
            o_done <= state_ff == ASX_EXEC;
            o_busy <= (state_ff == ASX_IDLE) ? i_start
                                             : (state_ff == ASX_FETCH);
            o_reg_wr <= state_ff == ASX_EXEC && nxt_to_reg;
            o_reg_wr_addr <= addr_ff;
            o_reg_wr_data <= nxt_res;
        end
    end
endmodule : asx_alu

// ==== asx_map.svh ====
// Constants for the subtract, exclusive-or and nibble-exchange datapath slice
`ifndef ASX_MAP_SVH
`define ASX_MAP_SVH
`define ASX_DATA_W 8
`define ASX_ADDR_W 7
`define ASX_REG_DEPTH 128
`define ASX_ACC_RST 8'h00
`define ASX_FLAG_RST 1'b0
`define ASX_DEST_ACC 1'b0
`define ASX_DEST_REG 1'b1
`define ASX_NIB_LO 3
`define ASX_NIB_HI 7
`define ASX_OP_NONE 6'h01
`define ASX_OP_LIT_SUB 6'h02
`define ASX_OP_LIT_XOR 6'h04
`define ASX_OP_REG_SUB 6'h08
`define ASX_OP_SWAP 6'h10
`define ASX_OP_REG_XOR 6'h20
`endif

// ==== asx_pkg.sv ====
// Types shared by the datapath slice
package asx_pkg;
    // One-hot operation codes
    typedef enum logic [5:0] {
        ASX_NONE    = 6'h01,
        ASX_LIT_SUB = 6'h02,
        ASX_LIT_XOR = 6'h04,
        ASX_REG_SUB = 6'h08,
        ASX_SWAP    = 6'h10,
        ASX_REG_XOR = 6'h20
    } asx_op_t;
endpackage : asx_pkg

// ==== asx_regfile.sv ====
// Small register file with registered read data
`timescale 1ns/1ps
module asx_regfile #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7,
    parameter int DEPTH = 128
) (
    // Clock
    input wire logic i_clk_sys,
    // Write port
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    // Read port
    input wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [DATA_W-1:0] o_rd_data
);
    // Storage array, no reset so it maps to RAM
    logic [DATA_W-1:0] mem_ff [DEPTH];

    // Write on strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr_en)
        begin
            mem_ff[i_wr_addr] <= i_wr_data;
        end
    end

    // Registered read, old data on same-address collision
    always_ff @(posedge i_clk_sys)
    begin
        o_rd_data <= mem_ff[i_rd_addr];
    end
endmodule : asx_regfile

// ==== asx_rf_loader.sv ====
// Decoder-side model that preloads the register file after reset
`timescale 1ns/1ps
module asx_rf_loader (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Preload write port
    output logic o_rf_wr,
    output logic [6:0] o_rf_addr,
    output logic [7:0] o_rf_data,
    output logic o_loaded
);
    logic [1:0] idx_ff; // Next table entry

    // Step through three entries once after reset, whatever the slice state
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            idx_ff <= 2'h0;
        else if (idx_ff != 2'h3)
            idx_ff <= idx_ff + 2'h1;
    end

    // Preload table, top address included as a boundary
    always_comb
    begin
        case (idx_ff)
            2'h0: {o_rf_addr, o_rf_data} = {7'h05, 8'h3c};
            2'h1: {o_rf_addr, o_rf_data} = {7'h7f, 8'ha5};
            default: {o_rf_addr, o_rf_data} = {7'h00, 8'hf9};
        endcase
    end
    assign o_rf_wr = !i_reset && (idx_ff != 2'h3);
    assign o_loaded = (idx_ff == 2'h3);
endmodule : asx_rf_loader

// ==== asx_alu_props.sv ====
// Checker of the datapath slice ports
`timescale 1ns/1ps
module asx_alu_props #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    // Clock, reset and request
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_start,
    input wire asx_pkg::asx_op_t i_op,
    input wire logic [DATA_W-1:0] i_literal,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic i_dest_sel,
    // Results
    input wire logic [DATA_W-1:0] o_acc,
    input wire logic o_carry,
    input wire logic o_digit_carry_flag,
    input wire logic o_zero,
    input wire logic o_done,
    input wire logic o_busy,
    input wire logic o_reg_wr,
    input wire logic [ADDR_W-1:0] o_reg_wr_addr
);
    import asx_pkg::*;
    asx_op_t op_ff; // Operation taken
    logic [DATA_W-1:0] lit_ff; // Literal taken
    logic [DATA_W-1:0] acc_ff; // Accumulator at start
    logic [ADDR_W-1:0] adr_ff; // Register address taken
    logic dst_ff; // Destination taken
    logic [2:0] fl_ff; // Flags at start

    // Capture only accepted requests; refused ones must leave no trace
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            op_ff <= ASX_NONE;
        else if (i_start && !o_busy)
        begin
            op_ff <= i_op;
            lit_ff <= i_literal;
            acc_ff <= o_acc;
            adr_ff <= i_reg_addr;
            dst_ff <= i_dest_sel;
            fl_ff <= {o_carry, o_digit_carry_flag, o_zero};
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    property p_lit_sub;
        o_done && op_ff == ASX_LIT_SUB |->
            o_acc == DATA_W'(lit_ff - acc_ff) && o_zero == (o_acc == 0);
    endproperty
    a_lit_sub: assert property (p_lit_sub) else $error("lit sub");
    property p_borrow;
        o_done && op_ff == ASX_LIT_SUB |-> o_carry == (lit_ff >= acc_ff)
            && o_digit_carry_flag == (lit_ff[3:0] >= acc_ff[3:0]);
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow");
    property p_lit_xor;
        o_done && op_ff == ASX_LIT_XOR |-> o_acc == (lit_ff ^ acc_ff)
            && o_zero == (o_acc == 0) && o_carry == fl_ff[2];
    endproperty
    a_lit_xor: assert property (p_lit_xor) else $error("lit xor");
    property p_swap;
        o_done && op_ff == ASX_SWAP |->
            {o_carry, o_digit_carry_flag, o_zero} == fl_ff;
    endproperty
    a_swap: assert property (p_swap) else $error("swap flags");
    property p_reg_sub;
        i_start && !o_busy && i_op == ASX_REG_SUB |=> o_busy[*2] ##1 o_done;
    endproperty
    a_reg_sub: assert property (p_reg_sub) else $error("sub time");
    property p_reg_xor;
        o_done && op_ff == ASX_REG_XOR |->
            {o_carry, o_digit_carry_flag} == fl_ff[2:1];
    endproperty
    a_reg_xor: assert property (p_reg_xor) else $error("xor flags");
    property p_dest;
        o_done && dst_ff && op_ff inside {ASX_REG_SUB, ASX_SWAP, ASX_REG_XOR}
            |-> o_reg_wr && o_reg_wr_addr == adr_ff && o_acc == acc_ff;
    endproperty
    a_dest: assert property (p_dest) else $error("dest reg");
    property p_wr_only;
        o_reg_wr |-> o_done && dst_ff;
    endproperty
    a_wr_only: assert property (p_wr_only) else $error("stray write");
endmodule : asx_alu_props

bind asx_alu asx_alu_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_asx_alu_props (
    .i_clk_sys, .i_reset, .i_start, .i_op, .i_literal, .i_reg_addr,
    .i_dest_sel, .o_acc, .o_carry, .o_digit_carry_flag, .o_zero, .o_done,
    .o_busy, .o_reg_wr, .o_reg_wr_addr);

// ==== asx_alu_tb.sv ====
// Self-checking bench of the datapath slice
`timescale 1ns/1ps
module asx_alu_tb;
    import asx_pkg::*;
    typedef struct {asx_op_t op; logic [7:0] k; logic [6:0] f; logic d;
        logic [7:0] acc; logic [2:0] fl; logic wr; logic [7:0] wd;} asx_row_t;
    logic i_clk_sys = 0, i_reset = 1, i_start = 0, i_dest_sel = 0;
    asx_op_t i_op = ASX_NONE;
    logic [7:0] i_literal = 8'h00, o_acc, o_reg_wr_data, rf_data;
    logic [6:0] i_reg_addr = 7'h00, o_reg_wr_addr, rf_addr;
    logic o_carry, o_digit_carry_flag, o_zero, o_done, o_busy, o_reg_wr;
    logic rf_wr, loaded;
    int n_errors = 0, check_count = 0;
    // Chained rows: each starts from the previous accumulator and flags
    asx_row_t rows [11] = '{
        '{ASX_LIT_SUB, 8'h10, 7'h00, 0, 8'h10, 3'h6, 0, 8'h00},
        '{ASX_LIT_XOR, 8'h10, 7'h00, 0, 8'h00, 3'h7, 0, 8'h00},
        '{ASX_LIT_XOR, 8'hff, 7'h00, 0, 8'hff, 3'h6, 0, 8'h00},
        '{ASX_LIT_SUB, 8'h01, 7'h00, 0, 8'h02, 3'h0, 0, 8'h00},
        '{ASX_REG_SUB, 8'h00, 7'h05, 0, 8'h3a, 3'h6, 0, 8'h00},
        '{ASX_REG_XOR, 8'h00, 7'h7f, 1, 8'h3a, 3'h6, 1, 8'h9f},
        '{ASX_SWAP, 8'h00, 7'h7f, 0, 8'hf9, 3'h6, 0, 8'h00},
        '{ASX_SWAP, 8'h00, 7'h05, 1, 8'hf9, 3'h6, 1, 8'hc3},
        '{ASX_REG_SUB, 8'h00, 7'h05, 1, 8'hf9, 3'h0, 1, 8'hca},
        '{ASX_REG_SUB, 8'h00, 7'h00, 0, 8'h00, 3'h7, 0, 8'h00},
        '{ASX_NONE, 8'h00, 7'h00, 0, 8'h00, 3'h7, 0, 8'h00}};

    asx_rf_loader i_asx_rf_loader (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .o_rf_wr(rf_wr), .o_rf_addr(rf_addr), .o_rf_data(rf_data),
        .o_loaded(loaded));
    asx_alu i_asx_alu (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_start(i_start), .i_op(i_op), .i_literal(i_literal),
        .i_reg_addr(i_reg_addr), .i_dest_sel(i_dest_sel), .i_rf_wr(rf_wr),
        .i_rf_addr(rf_addr), .i_rf_data(rf_data), .o_acc(o_acc),
        .o_carry(o_carry), .o_digit_carry_flag(o_digit_carry_flag),
        .o_zero(o_zero), .o_done(o_done), .o_busy(o_busy),
        .o_reg_wr(o_reg_wr), .o_reg_wr_addr(o_reg_wr_addr),
        .o_reg_wr_data(o_reg_wr_data));

    // 200 MHz clock
    initial
    begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // One request; dup repeats it while busy with a changed literal
    task automatic run(input asx_row_t r, input logic dup);
        int n;
        @(posedge i_clk_sys);
        {i_start, i_op, i_literal} <= {1'b1, r.op, r.k};
        {i_reg_addr, i_dest_sel} <= {r.f, r.d};
        @(posedge i_clk_sys);
        i_start <= dup;
        i_literal <= ~r.k;
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        n = 0;
        #1;
        while (o_done !== 1'b1 && n < 8)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        chk("done", {7'h00, o_done}, 8'h01);
        chk("acc", o_acc, r.acc);
        chk("flags", {5'h00, o_carry, o_digit_carry_flag, o_zero},
            {5'h00, r.fl});
        chk("wr", {7'h00, o_reg_wr}, {7'h00, r.wr});
        if (r.wr)
            chk("wdata", o_reg_wr_data, r.wd);
    endtask : run

    // Watchdog
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        chk("loaded", {7'h00, loaded}, 8'h01);
        foreach (rows[i])
            run(rows[i], 1'b0);
        // Second request while busy is ignored: one result, one done
        run('{ASX_LIT_XOR, 8'h55, 7'h00, 0, 8'h55, 3'h6, 0, 8'h00}, 1'b1);
        repeat (4)
        begin
            @(posedge i_clk_sys);
            #1;
            chk("no done", {7'h00, o_done}, 8'h00);
        end
        // Reset in mid-operation clears state
        @(posedge i_clk_sys);
        {i_start, i_op} <= {1'b1, ASX_LIT_SUB};
        @(posedge i_clk_sys);
        {i_start, i_reset} <= 2'h1;
        @(posedge i_clk_sys);
        i_reset <= 1'b0;
        #1;
        chk("rst", {o_acc[6:0], o_busy}, 8'h00);
        end_of_test();
    end
endmodule : asx_alu_tb
